//--- design/arbg_pkg.sv
// package for the reference and buffer gating block
package arbg_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] CONV_OFS = 4'h4;
	localparam logic [3:0] STAT_OFS = 4'h8;
	// control field positions
	localparam int CORE_ON_BIT = 0;
	localparam int REF_ON_BIT = 1;
	localparam int PIN_ROUTE_BIT = 2;
	localparam int BURST_BIT = 3;
	// conversion field positions
	localparam int CHAN_LSB = 0;
	localparam int SREF_LSB = 4;
	// status field positions
	localparam int ST_BUF_BIT = 0;
	localparam int ST_PIN_BIT = 1;
	localparam int ST_SENS_BIT = 2;
	localparam int ST_CORE_BIT = 3;
	localparam int ST_REF_BIT = 4;
	localparam int ST_WIN_BIT = 5;
	// reset values and codes
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [3:0] CHAN_RST = 4'h0;
	localparam logic [2:0] SREF_RST = 3'h0;
	localparam logic [3:0] TEMP_SENSOR_CHANNEL = 4'ha;
	localparam logic [2:0] SREF_INT_A = 3'h1;
	localparam logic [2:0] SREF_INT_B = 3'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic reference_burst_mode;
		logic pin_route;
		logic reference_on;
		logic converter_core_on;
	} arbg_ctrl_t;

	typedef struct packed {
		logic buffer_en;
		logic pin_en;
		logic sensor_en;
	} arbg_gate_t;
endpackage : arbg_pkg

//--- design/arbg_gate.sv
// combinational gating decision for buffer, pin and sensor supply
`timescale 1ns/1ps
`default_nettype none
module arbg_gate import arbg_pkg::*; (
	// control
	input wire arbg_ctrl_t ctrl_i,
	input wire logic [3:0] chan_i,
	input wire logic [2:0] sref_i,
	input wire logic window_i,
	// decision
	output arbg_gate_t gate_o
);
	logic uses_ref;
	assign uses_ref = (sref_i == SREF_INT_A) || (sref_i == SREF_INT_B);

	always_comb begin
		gate_o = '0;
		if (!ctrl_i.reference_on) begin
			gate_o.buffer_en = 1'b0;
			gate_o.pin_en = 1'b0;
		end else if (!ctrl_i.pin_route) begin
			gate_o.buffer_en = window_i && uses_ref;
		end else if (!ctrl_i.reference_burst_mode) begin
			gate_o.buffer_en = 1'b1;
			gate_o.pin_en = 1'b1;
		end else begin
			gate_o.buffer_en = window_i && uses_ref;
			gate_o.pin_en = window_i && uses_ref;
		end
		gate_o.sensor_en = window_i && (chan_i == TEMP_SENSOR_CHANNEL);
	end
endmodule : arbg_gate
`default_nettype wire

//--- design/arbg_axil.sv
// axi4-lite slave holding control and conversion settings
`timescale 1ns/1ps
`default_nettype none
module arbg_axil import arbg_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// axi4-lite
	input wire logic [3:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [3:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	// block side
	input wire logic [5:0] status_i,
	output arbg_ctrl_t ctrl_o,
	output logic [3:0] chan_o,
	output logic [2:0] sref_o
);
	logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic [3:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;
	arbg_ctrl_t ctrl_q, ctrl_d;
	logic [3:0] chan_q, chan_d;
	logic [2:0] sref_q, sref_d;
	// ready flags are registered so every bus output leaves a flop
	logic awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;

	always_comb begin
		aw_d = aw_q;
		w_d = w_q;
		awa_d = awa_q;
		wd_d = wd_q;
		bv_d = bv_q;
		br_d = br_q;
		rv_d = rv_q;
		rd_d = rd_q;
		rr_d = rr_q;
		ctrl_d = ctrl_q;
		chan_d = chan_q;
		sref_d = sref_q;
		if (awvalid_i && !aw_q && !bv_q) begin
			aw_d = 1'b1;
			awa_d = awaddr_i;
		end
		if (wvalid_i && !w_q && !bv_q) begin
			w_d = 1'b1;
			wd_d = wdata_i;
		end
		// ----------------------------------------
		// write commit once both halves are held
		// ----------------------------------------
		if (aw_q && w_q) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bv_d = 1'b1;
			br_d = RESP_OKAY;
			unique case (awa_q)
				CTRL_OFS: ctrl_d = arbg_ctrl_t'(wd_q[3:0]);
				CONV_OFS: begin
					chan_d = wd_q[CHAN_LSB +: 4];
					sref_d = wd_q[SREF_LSB +: 3];
				end
				STAT_OFS: br_d = RESP_OKAY;
				default: br_d = RESP_SLVERR;
			endcase
		end
		if (bv_q && bready_i) bv_d = 1'b0;
		if (arvalid_i && !rv_q) begin
			rv_d = 1'b1;
			rr_d = RESP_OKAY;
			unique case (araddr_i)
				CTRL_OFS: rd_d = {28'h0, ctrl_q};
				CONV_OFS: rd_d = {25'h0, sref_q, chan_q};
				STAT_OFS: rd_d = {26'h0, status_i};
				default: begin
					rd_d = 32'h0;
					rr_d = RESP_SLVERR;
				end
			endcase
		end else if (rv_q && rready_i) rv_d = 1'b0;
		awr_d = !aw_d && !bv_d;
		wr_d = !w_d && !bv_d;
		arr_d = !rv_d;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 4'h0;
			wd_q <= 32'h0;
			bv_q <= 1'b0;
			br_q <= RESP_OKAY;
			rv_q <= 1'b0;
			rd_q <= 32'h0;
			rr_q <= RESP_OKAY;
			ctrl_q <= arbg_ctrl_t'(CTRL_RST);
			chan_q <= CHAN_RST;
			sref_q <= SREF_RST;
			awr_q <= 1'b1;
			wr_q <= 1'b1;
			arr_q <= 1'b1;
		end else begin
			aw_q <= aw_d;
			w_q <= w_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			bv_q <= bv_d;
			br_q <= br_d;
			rv_q <= rv_d;
			rd_q <= rd_d;
			rr_q <= rr_d;
			ctrl_q <= ctrl_d;
			chan_q <= chan_d;
			sref_q <= sref_d;
			awr_q <= awr_d;
			wr_q <= wr_d;
			arr_q <= arr_d;
		end
	end

	assign awready_o = awr_q;
	assign wready_o = wr_q;
	assign bvalid_o = bv_q;
	assign bresp_o = br_q;
	assign arready_o = arr_q;
	assign rvalid_o = rv_q;
	assign rdata_o = rd_q;
	assign rresp_o = rr_q;
	assign ctrl_o = ctrl_q;
	assign chan_o = chan_q;
	assign sref_o = sref_q;
endmodule : arbg_axil
`default_nettype wire

//--- design/arbg_top.sv
// reference, buffer and pin power gating for the converter
`timescale 1ns/1ps
`default_nettype none
// How it works
// - reference off: pin off, sensor in window
// - internal reference used, pin not routed: buffer only in window
// - pin routed, no burst: buffer always on
// - burst: buffer in window for select 1/5
// - burst: pin present with buffer only
// - sensor supplied in window despite reference off
// - core and reference switch independently
module arbg_top import arbg_pkg::*; (
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	// sequencer
	input wire logic CONV_ACTIVE_I,
	// axi4-lite
	input wire logic [3:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [3:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// analog enables
	output logic REF_BUFFER_EN_O,
	output logic REF_PIN_EN_O,
	output logic SENSOR_SUPPLY_EN_O,
	output logic CORE_POWER_O,
	output logic REF_POWER_O
);
	arbg_ctrl_t ctrl;
	logic [3:0] chan;
	logic [2:0] sref;
	arbg_gate_t gate;
	logic [5:0] status;
	arbg_gate_t gate_q, gate_d;
	logic core_q, core_d, refp_q, refp_d;

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	arbg_axil u_regs (
		.clk_i(CLOCK_I),
		.rst_i(SYS_RST_I),
		.awaddr_i(S_AXI_AWADDR_I),
		.awvalid_i(S_AXI_AWVALID_I),
		.awready_o(S_AXI_AWREADY_O),
		.wdata_i(S_AXI_WDATA_I),
		.wstrb_i(S_AXI_WSTRB_I),
		.wvalid_i(S_AXI_WVALID_I),
		.wready_o(S_AXI_WREADY_O),
		.bresp_o(S_AXI_BRESP_O),
		.bvalid_o(S_AXI_BVALID_O),
		.bready_i(S_AXI_BREADY_I),
		.araddr_i(S_AXI_ARADDR_I),
		.arvalid_i(S_AXI_ARVALID_I),
		.arready_o(S_AXI_ARREADY_O),
		.rdata_o(S_AXI_RDATA_O),
		.rresp_o(S_AXI_RRESP_O),
		.rvalid_o(S_AXI_RVALID_O),
		.rready_i(S_AXI_RREADY_I),
		.status_i(status),
		.ctrl_o(ctrl),
		.chan_o(chan),
		.sref_o(sref)
	);

	// ----------------------------------------
	// gating decision
	// ----------------------------------------
	arbg_gate u_gate (
		.ctrl_i(ctrl),
		.chan_i(chan),
		.sref_i(sref),
		.window_i(CONV_ACTIVE_I),
		.gate_o(gate)
	);

	always_comb begin
		gate_d = gate;
		core_d = ctrl.converter_core_on;
		refp_d = ctrl.reference_on;
	end

	// enables register one cycle after the window edge
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			gate_q <= '0;
			core_q <= 1'b0;
			refp_q <= 1'b0;
		end else begin
			gate_q <= gate_d;
			core_q <= core_d;
			refp_q <= refp_d;
		end
	end

	assign status = {CONV_ACTIVE_I, refp_q, core_q, gate_q.sensor_en, gate_q.pin_en,
		gate_q.buffer_en};
	assign REF_BUFFER_EN_O = gate_q.buffer_en;
	assign REF_PIN_EN_O = gate_q.pin_en;
	assign SENSOR_SUPPLY_EN_O = gate_q.sensor_en;
	assign CORE_POWER_O = core_q;
	assign REF_POWER_O = refp_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	logic uses_ref_q;
	always_ff @(posedge CLOCK_I) uses_ref_q <= (sref == SREF_INT_A) || (sref == SREF_INT_B);

	refoff_pin_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		!$past(ctrl.reference_on) |-> !REF_PIN_EN_O) else $error("pin on with reference off");
	sensor_win_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		SENSOR_SUPPLY_EN_O |-> $past(CONV_ACTIVE_I) && $past(chan) == TEMP_SENSOR_CHANNEL)
		else $error("sensor supplied outside window");
	sensor_on_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		CONV_ACTIVE_I && chan == TEMP_SENSOR_CHANNEL |=> SENSOR_SUPPLY_EN_O)
		else $error("sensor not supplied in window");
	int_buf_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		ctrl.reference_on && !ctrl.pin_route && CONV_ACTIVE_I && uses_ref_q == 1'b1 ##0
		(sref == SREF_INT_A || sref == SREF_INT_B) |=> REF_BUFFER_EN_O)
		else $error("buffer not on in window");
	unused_buf_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		ctrl.reference_on && !ctrl.pin_route && sref != SREF_INT_A && sref != SREF_INT_B
		|=> !REF_BUFFER_EN_O) else $error("buffer on while unused");
	cont_buf_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		(ctrl.reference_on && ctrl.pin_route && !ctrl.reference_burst_mode) [*2]
		|-> REF_BUFFER_EN_O && REF_PIN_EN_O) else $error("continuous buffer dropped");
	burst_buf_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		ctrl.reference_on && ctrl.pin_route && ctrl.reference_burst_mode && !CONV_ACTIVE_I
		|=> !REF_BUFFER_EN_O) else $error("burst buffer outside window");
	burst_pin_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		ctrl.reference_burst_mode && ctrl.pin_route |=> REF_PIN_EN_O == REF_BUFFER_EN_O)
		else $error("pin and buffer differ in burst");
	win_end_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		$fell(CONV_ACTIVE_I) && !(ctrl.reference_on && ctrl.pin_route &&
		!ctrl.reference_burst_mode) |=> !REF_BUFFER_EN_O && !SENSOR_SUPPLY_EN_O)
		else $error("enables outlive window");
	indep_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		##1 CORE_POWER_O == $past(ctrl.converter_core_on) && REF_POWER_O == $past(ctrl.reference_on))
		else $error("power bits not independent");

	burst_cv: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		REF_PIN_EN_O && ctrl.reference_burst_mode);
	sensor_cv: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		SENSOR_SUPPLY_EN_O && !REF_POWER_O);
	cont_cv: cover property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		REF_BUFFER_EN_O && !CONV_ACTIVE_I);
endmodule : arbg_top
`default_nettype wire

//--- verif/arbg_seq_model.sv
// sequencer model driving the conversion-active window
`timescale 1ns/1ps
`default_nettype none
module arbg_seq_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// window request
	input wire logic start_i,
	input wire logic [3:0] len_i,
	// window
	output logic conv_active_o
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	// a new window starts only once the previous one has ended
	always_comb begin
		cnt_d = cnt_q;
		if (cnt_q != 4'h0) begin
			cnt_d = cnt_q - 4'h1;
		end else if (start_i) begin
			cnt_d = len_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	assign conv_active_o = (cnt_q != 4'h0);
endmodule : arbg_seq_model
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the reference and buffer gating block
`timescale 1ns/1ps
`default_nettype none
module tb import arbg_pkg::*; ;
	logic clk = 0, rst = 1, start = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic [3:0] len = 0, awaddr = 0, araddr = 0, sh_chan = 0;
	logic [31:0] wd = 0, rd;
	logic awr, wr, bv, arr, rv, buf_o, pin, sens, core, refp, win, chk_en = 0;
	logic [1:0] br, rr;
	logic [2:0] sh_sref = 0;
	arbg_ctrl_t sh_ctrl = 4'h0;
	int error_cnt = 0, checked = 0, cyc = 0;
	always #50 clk = ~clk;
	arbg_top DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .CONV_ACTIVE_I(win),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
		.S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
		.S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready),
		.REF_BUFFER_EN_O(buf_o), .REF_PIN_EN_O(pin), .SENSOR_SUPPLY_EN_O(sens),
		.CORE_POWER_O(core), .REF_POWER_O(refp));
	arbg_seq_model seq (.clk_i(clk), .rst_i(rst), .start_i(start), .len_i(len),
		.conv_active_o(win));
	// ----------------------------------------
	// expectations and reporting
	// ----------------------------------------
	// {buffer, pin, sensor} for one control setting and window level
	function automatic logic [2:0] exp_gate(arbg_ctrl_t c, logic [3:0] ch, logic [2:0] s,
		logic w);
		logic b;
		logic p;
		b = 1'b0;
		p = 1'b0;
		if (c.reference_on && c.pin_route && !c.reference_burst_mode) begin
			b = 1'b1;
			p = 1'b1;
		end else if (c.reference_on) begin
			b = w && (s === SREF_INT_A || s === SREF_INT_B);
			p = b && c.pin_route;
		end
		return {b, p, w && (ch === TEMP_SENSOR_CHANNEL)};
	endfunction : exp_gate
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	// outputs at each edge follow window and settings seen at the edge before
	always @(posedge clk) begin
		logic [2:0] e;
		logic [1:0] pw;
		cyc <= cyc + 1;
		if (cyc >= 30000) begin
			error_cnt++;
			summarize();
		end
		e = exp_gate(sh_ctrl, sh_chan, sh_sref, win);
		pw = {sh_ctrl.converter_core_on, sh_ctrl.reference_on};
		if (chk_en) begin
			#1;
			chk({29'h0, buf_o, pin, sens}, {29'h0, e});
			chk({30'h0, core, refp}, {30'h0, pw});
		end
	end
	// ----------------------------------------
	// axi4-lite master
	// ----------------------------------------
	// ready and valid are registered, so the value before the edge is the one taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] dat, output logic [1:0] resp);
		logic aw_r, w_r, b_v;
		@(posedge clk);
		awaddr <= a;
		awv <= 1'b1;
		wd <= dat;
		wv <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(negedge clk);
			aw_r = awr;
			w_r = wr;
			b_v = bv;
			resp = br;
			@(posedge clk);
			if (aw_r) awv <= 1'b0;
			if (w_r) wv <= 1'b0;
			if (b_v) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] resp);
		logic a_r, r_v;
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(negedge clk);
			a_r = arr;
			r_v = rv;
			dat = rd;
			resp = rr;
			@(posedge clk);
			if (a_r) arv <= 1'b0;
			if (r_v) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask : axi_rd
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [1:0] r;
		logic [31:0] d;
		logic [3:0] ch;
		logic [2:0] e;
		arbg_ctrl_t c;
		void'($urandom(88974));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		axi_rd(CTRL_OFS, d, r);
		chk(d, 32'h0);
		axi_rd(CONV_OFS, d, r);
		chk(d, 32'h0);
		axi_rd(4'hc, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		axi_wr(STAT_OFS, 32'hffffffff, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		for (int i = 0; i < 128; i++) begin
			c = i[3:0];
			ch = ($urandom_range(1) == 1) ? TEMP_SENSOR_CHANNEL : 4'($urandom);
			sh_ctrl <= c;
			sh_sref <= i[6:4];
			sh_chan <= ch;
			axi_wr(CTRL_OFS, {28'h0, c}, r);
			chk({30'h0, r}, {30'h0, RESP_OKAY});
			axi_wr(CONV_OFS, {25'h0, i[6:4], ch}, r);
			chk({30'h0, r}, {30'h0, RESP_OKAY});
			axi_rd(CONV_OFS, d, r);
			chk(d, {25'h0, i[6:4], ch});
			axi_rd(STAT_OFS, d, r);
			e = exp_gate(c, ch, i[6:4], 1'b0);
			chk(d, {26'h0, 1'b0, c.reference_on, c.converter_core_on, e[0], e[1], e[2]});
			chk_en <= 1'b1;
			repeat (3) begin
				start <= 1'b1;
				len <= 4'($urandom_range(1, 6));
				@(posedge clk);
				start <= 1'b0;
				repeat ($urandom_range(1, 9)) @(posedge clk);
			end
			repeat (8) @(posedge clk);
			chk_en <= 1'b0;
		end
		// mid-run reset: enables drop and registers return to reset values
		@(posedge clk);
		rst <= 1'b1;
		chk_en <= 1'b1;
		sh_ctrl <= arbg_ctrl_t'(CTRL_RST);
		sh_chan <= CHAN_RST;
		sh_sref <= SREF_RST;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		axi_rd(CTRL_OFS, d, r);
		chk(d, {28'h0, CTRL_RST});
		axi_rd(CONV_OFS, d, r);
		chk(d, {25'h0, SREF_RST, CHAN_RST});
		summarize();
	end
endmodule : tb
`default_nettype wire
